/* hw/sprsc_pkg.sv */
// Constants and layouts for the secondary port reset and strap control
// Summary of operation
// - Secondary reset follows primary reset or control bit
// - In reset: controls float, AD/CBE/PAR zero
// - Disabled port floats its output enables at once, unclocked; reset and grant stay driven
// - Fast-capable high allows fast secondary clock
// - Central function pin picks internal or external arbiter
// - External arbiter: request[0] grants, grant[0] requests
// - Eight clock outputs per port, primary-clock locked
// - Scan mode enables ten chains on request/grant pins
// - Scan control low shifts, high captures
// - Idle bus with our grant: park AD/CBE/PAR
`default_nettype none
package sprsc_pkg;
  localparam logic [3:0]  SPRSC_CTRL_OFS        = 4'h0;
  localparam logic [3:0]  SPRSC_STAT_OFS        = 4'h4;
  localparam int unsigned SPRSC_CTRL_RST_POS    = 0;    // One reset bit per port
  localparam int unsigned SPRSC_CTRL_REQ_POS    = 2;    // One bus request bit per port
  localparam logic [3:0]  SPRSC_CTRL_RESET      = 4'h0;
  localparam logic [1:0]  SPRSC_STRAP_LATCH_CYC = 2'h2; // Sync depth before straps are valid
  localparam logic [1:0]  SPRSC_FAST_HALF       = 2'h1; // Ref cycles per fanout half period
  localparam logic [1:0]  SPRSC_SLOW_HALF       = 2'h2; // Half the fast rate
  localparam int unsigned SPRSC_SCAN_PER_PORT   = 5;
  localparam int unsigned SPRSC_SCAN_LOW_PIN    = 2;

  // Pin inputs as they pass the two-stage synchroniser
  typedef struct packed {
    logic       en1, en2, fast1, fast2, priFast, cfnN;
    logic       skip, pllTest, sclk, scanN, scanCapture;
    logic       frame1N, irdy1N, frame2N, irdy2N;
    logic [7:0] req1N, req2N;
  } sprsc_pins_type;

  // Status word, bit 0 is resetActive[0]
  typedef struct packed {
    logic [17:0] rsvd;
    logic        sclkStrap, pllTest, pllSkip, scanMode, priFast, extArb;
    logic [1:0]  enable, fast, granted, resetActive;
  } sprsc_stat_type;
endpackage : sprsc_pkg
`default_nettype wire

/* hw/sprsc_port_if.sv */
// Signals between the top level and one secondary port controller
`default_nettype none
interface sprsc_port_if #(parameter int unsigned ADW = 32, NREQ = 8, NCLK = 8);
  logic            secReset, portEnable, fastClock, extArb, ownRequest, busIdle;
  logic            scanMode, scanCapture;
  logic [NREQ-1:0] reqN, gntN;
  logic            resetOutN, ctrlOe, granted, clkOe, parOut, parOe;
  logic [ADW-1:0]  adOut, adOe;
  logic [ADW/8-1:0] cbeOut, cbeOe;
  logic [NCLK-1:0] clkOut;
  modport ctl (input secReset, portEnable, fastClock, extArb, ownRequest, busIdle, scanMode, scanCapture,
               reqN, output gntN, resetOutN, ctrlOe, granted, clkOe, parOut, parOe, adOut, adOe,
               cbeOut, cbeOe, clkOut);
  modport top (output secReset, portEnable, fastClock, extArb, ownRequest, busIdle, scanMode, scanCapture,
               reqN, input gntN, resetOutN, ctrlOe, granted, clkOe, parOut, parOe, adOut, adOe,
               cbeOut, cbeOe, clkOut);
endinterface : sprsc_port_if
`default_nettype wire

/* hw/sprsc_port.sv */
// One secondary port: reset hold, parking, arbitration, clock fanout and scan
`default_nettype none
module sprsc_port import sprsc_pkg::*; #(
  parameter int unsigned ADW  = 32,
  parameter int unsigned NREQ = 8,
  parameter int unsigned NCLK = 8
) (
  input  wire logic  ref_clk,
  input  wire logic  arst_n,
  sprsc_port_if.ctl  p
);
  if (NREQ < SPRSC_SCAN_LOW_PIN + SPRSC_SCAN_PER_PORT || ADW % 8 != 0 || NCLK == 0) begin : g_chk
    $error("sprsc_port: unsupported width");
  end

  typedef struct packed {
    logic            resetOutN, ctrlOe, drive, granted, clkBit;
    logic [NREQ-1:0] gntN;
    logic [1:0]      clkCnt;
  } sprsc_port_state_type;

  localparam sprsc_port_state_type ST_RESET = '{resetOutN: 1'b0, ctrlOe: 1'b0, drive: 1'b1,
    granted: 1'b0, clkBit: 1'b0, gntN: '1, clkCnt: 2'h0};

  sprsc_port_state_type st, next_st;
  logic [1:0] halfLast;
  logic [SPRSC_SCAN_PER_PORT-1:0] capVec;

  // Fixed priority, lowest index wins; fairness is left to the requesters
  function automatic logic [NREQ-1:0] grantOf(input logic [NREQ-1:0] reqN);
    logic [NREQ-1:0] g;
    logic            found;
    g     = '1;
    found = 1'b0;
    for (int i = 0; i < NREQ; i++) begin
      if (!reqN[i] && !found) begin
        g[i]  = 1'b0;
        found = 1'b1;
      end
    end
    return g;
  endfunction : grantOf

  assign capVec = {st.granted, p.busIdle, p.fastClock, p.extArb, p.secReset};

  // Next state
  always_comb begin
    next_st  = st;
    halfLast = (p.fastClock ? SPRSC_FAST_HALF : SPRSC_SLOW_HALF) - 2'h1;
    // Fanout clock, derived from the reference so its edges stay aligned to it
    if (st.clkCnt >= halfLast) begin
      next_st.clkCnt = 2'h0;
      next_st.clkBit = ~st.clkBit;
    end else begin
      next_st.clkCnt = st.clkCnt + 2'h1;
    end
    if (p.extArb) begin
      next_st.granted = ~p.reqN[0];
      next_st.gntN    = '1;
      next_st.gntN[0] = ~p.ownRequest;
    end else if (p.busIdle) begin
      next_st.gntN    = grantOf(p.reqN);
      next_st.granted = &p.reqN;
    end
    if (p.secReset) begin
      next_st.resetOutN = 1'b0;
      next_st.ctrlOe    = 1'b0;
      next_st.drive     = 1'b1;
      next_st.gntN      = '1;
      next_st.granted   = 1'b0;
    end else begin
      next_st.resetOutN = 1'b1;
      next_st.drive     = st.granted & p.busIdle;
      next_st.ctrlOe    = st.granted & ~p.busIdle;
    end
    // Each scan chain is one grant flop, fed from its request pin
    if (p.scanMode) begin
      for (int i = 0; i < SPRSC_SCAN_PER_PORT; i++) begin
        next_st.gntN[SPRSC_SCAN_LOW_PIN + i] = p.scanCapture ? capVec[i] : p.reqN[SPRSC_SCAN_LOW_PIN + i];
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Enable gates every output enable without a clock edge; reset and grant outputs stay driven
  assign p.resetOutN = st.resetOutN;
  assign p.ctrlOe    = st.ctrlOe & p.portEnable;
  assign p.adOut     = '0;
  assign p.adOe      = {ADW{st.drive & p.portEnable}};
  assign p.cbeOut    = '0;
  assign p.cbeOe     = {(ADW/8){st.drive & p.portEnable}};
  assign p.parOut    = 1'b0; // Parity of all-zero AD and CBE
  assign p.parOe     = st.drive & p.portEnable;
  assign p.gntN      = st.gntN;
  assign p.granted   = st.granted;
  assign p.clkOut    = {NCLK{st.clkBit}};
  assign p.clkOe     = p.portEnable;

  property p_reset_drive;
    @(posedge ref_clk) disable iff (!arst_n)
      (!p.resetOutN && p.portEnable) |-> (&p.adOe && p.adOut == '0 && &p.cbeOe && p.parOe && !p.ctrlOe);
  endproperty
  a_reset_drive: assert property (p_reset_drive) else $error("port not safe in reset");

  property p_disable_float;
    @(posedge ref_clk) disable iff (!arst_n)
      !p.portEnable |-> (p.adOe == '0 && p.cbeOe == '0 && !p.parOe && !p.ctrlOe && !p.clkOe);
  endproperty
  a_disable_float: assert property (p_disable_float) else $error("disabled port drives");

  property p_fast_clock;
    @(posedge ref_clk) disable iff (!arst_n)
      (p.fastClock && $past(p.fastClock)) |-> p.clkOut != $past(p.clkOut);
  endproperty
  a_fast_clock: assert property (p_fast_clock) else $error("fast fanout not toggling");

  property p_slow_clock;
    @(posedge ref_clk) disable iff (!arst_n)
      // The reset level holds no phase, so the window only opens once reset is gone
      (arst_n && !p.fastClock)[*3] |-> p.clkOut != $past(p.clkOut, 2);
  endproperty
  a_slow_clock: assert property (p_slow_clock) else $error("slow fanout wrong period");

  property p_ext_arb;
    @(posedge ref_clk) disable iff (!arst_n)
      (p.extArb && !p.secReset) |=> (p.granted == !$past(p.reqN[0]) && p.gntN[0] == !$past(p.ownRequest));
  endproperty
  a_ext_arb: assert property (p_ext_arb) else $error("external arbiter pins wrong");

  property p_int_park;
    @(posedge ref_clk) disable iff (!arst_n)
      (!p.extArb && !p.secReset && !p.scanMode && p.busIdle && &p.reqN) |=> (p.granted && &p.gntN);
  endproperty
  a_int_park: assert property (p_int_park) else $error("internal arbiter not parked");

  property p_park_drive;
    @(posedge ref_clk) disable iff (!arst_n)
      (p.granted && p.busIdle && !p.secReset) |=> (&p.adOe || !p.portEnable);
  endproperty
  a_park_drive: assert property (p_park_drive) else $error("idle granted bus not parked");

  property p_scan_shift;
    @(posedge ref_clk) disable iff (!arst_n)
      (p.scanMode && !p.scanCapture) |=>
        p.gntN[SPRSC_SCAN_LOW_PIN +: SPRSC_SCAN_PER_PORT] == $past(p.reqN[SPRSC_SCAN_LOW_PIN +: SPRSC_SCAN_PER_PORT]);
  endproperty
  a_scan_shift: assert property (p_scan_shift) else $error("scan shift wrong");

  property p_scan_capture;
    @(posedge ref_clk) disable iff (!arst_n)
      (p.scanMode && p.scanCapture) |=> p.gntN[SPRSC_SCAN_LOW_PIN +: SPRSC_SCAN_PER_PORT] == $past(capVec);
  endproperty
  a_scan_capture: assert property (p_scan_capture) else $error("scan capture wrong");
endmodule : sprsc_port
`default_nettype wire

/* hw/sprsc_top.sv */
// Top level: Wishbone registers, strap sampling and the two secondary ports
`default_nettype none
module sprsc_top import sprsc_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        pri_fast_clock_capable,
  input  wire logic        central_function_select_n,
  input  wire logic        pll_skip_strap,
  input  wire logic        pll_test_strap,
  input  wire logic        sec_clock_input_strap,
  input  wire logic        full_scan_mode_n,
  input  wire logic        scanCaptureSelect,
  input  wire logic        sec_one_port_enable,
  input  wire logic        sec_one_fast_clock_capable,
  input  wire logic [7:0]  sec_one_bus_request_n,
  input  wire logic        secOneFrameN,
  input  wire logic        secOneIrdyN,
  output logic             sec_one_reset_out_n,
  output logic      [7:0]  sec_one_bus_grant_n,
  output logic      [7:0]  sec_one_clock_fanout,
  output logic             secOneClockOe,
  output logic             secOneCtrlOe,
  output logic      [31:0] secOneAdOut,
  output logic      [31:0] secOneAdOe,
  output logic      [3:0]  secOneCbeOut,
  output logic      [3:0]  secOneCbeOe,
  output logic             secOneParOut,
  output logic             secOneParOe,
  input  wire logic        sec_two_port_enable,
  input  wire logic        sec_two_fast_clock_capable,
  input  wire logic [7:0]  sec_two_bus_request_n,
  input  wire logic        secTwoFrameN,
  input  wire logic        secTwoIrdyN,
  output logic             sec_two_reset_out_n,
  output logic      [7:0]  sec_two_bus_grant_n,
  output logic      [7:0]  sec_two_clock_fanout,
  output logic             secTwoClockOe,
  output logic             secTwoCtrlOe,
  output logic      [31:0] secTwoAdOut,
  output logic      [31:0] secTwoAdOe,
  output logic      [3:0]  secTwoCbeOut,
  output logic      [3:0]  secTwoCbeOe,
  output logic             secTwoParOut,
  output logic             secTwoParOe
);
  typedef struct packed {
    sprsc_pins_type meta, pins;
    logic [1:0]     strapCnt;
    logic           fast1, fast2, extArb;
    logic [3:0]     ctrl;
    logic           ack;
    logic [31:0]    rdData;
  } sprsc_top_state_type;

  sprsc_top_state_type st, next_st;
  sprsc_pins_type      pinsNow;
  sprsc_stat_type      stat;
  logic                wbReq;

  sprsc_port_if if1 ();
  sprsc_port_if if2 ();

  // Every pin input except the port enables crosses two flops before any logic looks at it
  assign pinsNow = '{en1: sec_one_port_enable, en2: sec_two_port_enable, fast1: sec_one_fast_clock_capable,
    fast2: sec_two_fast_clock_capable, priFast: pri_fast_clock_capable, cfnN: central_function_select_n,
    skip: pll_skip_strap, pllTest: pll_test_strap, sclk: sec_clock_input_strap, scanN: full_scan_mode_n,
    scanCapture: scanCaptureSelect, frame1N: secOneFrameN, irdy1N: secOneIrdyN, frame2N: secTwoFrameN,
    irdy2N: secTwoIrdyN, req1N: sec_one_bus_request_n, req2N: sec_two_bus_request_n};

  // Status readback
  always_comb begin
    stat             = '0;
    stat.sclkStrap   = st.pins.sclk;
    stat.pllTest     = st.pins.pllTest;
    stat.pllSkip     = st.pins.skip;
    stat.scanMode    = ~st.pins.scanN;
    stat.priFast     = st.pins.priFast;
    stat.extArb      = st.extArb;
    stat.enable      = {st.pins.en2, st.pins.en1};
    stat.fast        = {st.fast2, st.fast1};
    stat.granted     = {if2.granted, if1.granted};
    stat.resetActive = {~if2.resetOutN, ~if1.resetOutN};
  end

  assign wbReq = wb_cyc_i & wb_stb_i & ~st.ack;

  // Next state: synchroniser, strap latch, register access
  always_comb begin
    next_st        = st;
    next_st.meta   = pinsNow;
    next_st.pins   = st.meta;
    // Straps are static by design; the fast-capable and central function straps are sampled once so a glitch later changes nothing
    if (st.strapCnt == SPRSC_STRAP_LATCH_CYC) begin
      next_st.fast1  = st.pins.fast1;
      next_st.fast2  = st.pins.fast2;
      next_st.extArb = st.pins.cfnN;
    end
    if (st.strapCnt != 2'h3) begin
      next_st.strapCnt = st.strapCnt + 2'h1;
    end
    // Single-cycle Wishbone slave; unmapped words read zero and ignore writes
    next_st.ack    = wbReq;
    next_st.rdData = '0;
    if (wbReq && wb_adr_i == SPRSC_CTRL_OFS) begin
      next_st.rdData = 32'(st.ctrl);
      if (wb_we_i && wb_sel_i[0]) begin
        next_st.ctrl = wb_dat_i[3:0];
      end
    end else if (wbReq && wb_adr_i == SPRSC_STAT_OFS) begin
      next_st.rdData = stat;
    end
  end

  // State register; primary reset holds both ports in reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st      <= '0;
      st.ctrl <= SPRSC_CTRL_RESET;
      st.meta <= '1;
      st.pins <= '1;
    end else begin
      st <= next_st;
    end
  end

  // Port one wiring
  assign if1.secReset    = st.ctrl[SPRSC_CTRL_RST_POS];
  assign if1.portEnable  = sec_one_port_enable;
  assign if1.fastClock   = st.fast1;
  assign if1.extArb      = st.extArb;
  assign if1.ownRequest  = st.ctrl[SPRSC_CTRL_REQ_POS];
  assign if1.busIdle     = st.pins.frame1N & st.pins.irdy1N;
  assign if1.scanMode    = ~st.pins.scanN;
  assign if1.scanCapture = st.pins.scanCapture;
  assign if1.reqN        = st.pins.req1N;
  // Port two wiring
  assign if2.secReset    = st.ctrl[SPRSC_CTRL_RST_POS + 1];
  assign if2.portEnable  = sec_two_port_enable;
  assign if2.fastClock   = st.fast2;
  assign if2.extArb      = st.extArb;
  assign if2.ownRequest  = st.ctrl[SPRSC_CTRL_REQ_POS + 1];
  assign if2.busIdle     = st.pins.frame2N & st.pins.irdy2N;
  assign if2.scanMode    = ~st.pins.scanN;
  assign if2.scanCapture = st.pins.scanCapture;
  assign if2.reqN        = st.pins.req2N;

  sprsc_port u_port1 (.ref_clk(ref_clk), .arst_n(arst_n), .p(if1.ctl));
  sprsc_port u_port2 (.ref_clk(ref_clk), .arst_n(arst_n), .p(if2.ctl));

  // Outputs
  assign wb_dat_o             = st.rdData;
  assign wb_ack_o             = st.ack;
  assign sec_one_reset_out_n  = if1.resetOutN;
  assign sec_one_bus_grant_n  = if1.gntN;
  assign sec_one_clock_fanout = if1.clkOut;
  assign secOneClockOe        = if1.clkOe;
  assign secOneCtrlOe         = if1.ctrlOe;
  assign secOneAdOut          = if1.adOut;
  assign secOneAdOe           = if1.adOe;
  assign secOneCbeOut         = if1.cbeOut;
  assign secOneCbeOe          = if1.cbeOe;
  assign secOneParOut         = if1.parOut;
  assign secOneParOe          = if1.parOe;
  assign sec_two_reset_out_n  = if2.resetOutN;
  assign sec_two_bus_grant_n  = if2.gntN;
  assign sec_two_clock_fanout = if2.clkOut;
  assign secTwoClockOe        = if2.clkOe;
  assign secTwoCtrlOe         = if2.ctrlOe;
  assign secTwoAdOut          = if2.adOut;
  assign secTwoAdOe           = if2.adOe;
  assign secTwoCbeOut         = if2.cbeOut;
  assign secTwoCbeOe          = if2.cbeOe;
  assign secTwoParOut         = if2.parOut;
  assign secTwoParOe          = if2.parOe;

  property p_sec_reset;
    @(posedge ref_clk) disable iff (!arst_n)
      (st.ctrl[0] |=> !sec_one_reset_out_n) and (st.ctrl[1] |=> !sec_two_reset_out_n);
  endproperty
  a_sec_reset: assert property (p_sec_reset) else $error("secondary reset not asserted");

  property p_sec_release;
    @(posedge ref_clk) disable iff (!arst_n)
      ($rose(sec_one_reset_out_n) |-> !$past(st.ctrl[0])) and ($rose(sec_two_reset_out_n) |-> !$past(st.ctrl[1]));
  endproperty
  a_sec_release: assert property (p_sec_release) else $error("reset released while requested");
endmodule : sprsc_top
`default_nettype wire

/* verif/sprsc_bus_partner.sv */
// Behavioural model of the devices and external arbiter on one secondary bus
`default_nettype none
module sprsc_bus_partner (
  input  wire logic       ref_clk,
  input  wire logic       extMode,
  input  wire logic [3:0] grantLag,
  input  wire logic [7:0] reqWant,
  input  wire logic       busyWant,
  input  wire logic [7:0] grantN,
  output logic      [7:0] reqN,
  output logic            frameN,
  output logic            irdyN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitCnt = 4'h0;
  logic       arbGrant = 1'b0;

  initial begin
    reqN = 8'hff;
    frameN = 1'b1;
    irdyN = 1'b1;
  end

  // Arbiter answers grantLag + 1 cycles after it first sees grant[0] low, so slow replies are exercised too
  always @(posedge ref_clk) begin
    if (extMode && grantN[0] === 1'b0) begin
      if (waitCnt >= grantLag)
        arbGrant <= 1'b1;
      else
        waitCnt <= waitCnt + 4'h1;
    end else begin
      waitCnt <= 4'h0;
      arbGrant <= 1'b0;
    end
    reqN <= extMode ? {~reqWant[7:1], ~arbGrant} : ~reqWant;
    frameN <= ~busyWant;
    irdyN <= ~busyWant;
  end
endmodule : sprsc_bus_partner
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking testbench for the secondary port reset and strap control
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, arst_n, wbWe, wbCyc, wbStb, wbAck;
  logic [3:0]  wbAdr, wbSel, lag, cbe1, cbe2, cbeOe1, cbeOe2;
  logic [31:0] wbDatI, wbDatO, rdData, ad1, ad2, adOe1, adOe2;
  logic        priFast, cfnN, skip, pllTest, sclk, scanN, scanCap, en1, en2, fast1, fast2;
  logic [7:0]  req1N, req2N, gnt1N, gnt2N, fan1, fan2, want1, want2;
  logic        frame1N, irdy1N, frame2N, irdy2N, rst1N, rst2N, clkOe1, clkOe2;
  logic        ctrlOe1, ctrlOe2, par1, par2, parOe1, parOe2, busy1, busy2, extMode;
  int          errCount, numChecks;

  sprsc_top sprsc_top_inst (.ref_clk(ref_clk), .arst_n(arst_n), .wb_adr_i(wbAdr), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_ack_o(wbAck),
    .pri_fast_clock_capable(priFast), .central_function_select_n(cfnN), .pll_skip_strap(skip),
    .pll_test_strap(pllTest), .sec_clock_input_strap(sclk), .full_scan_mode_n(scanN), .scanCaptureSelect(scanCap),
    .sec_one_port_enable(en1), .sec_one_fast_clock_capable(fast1), .sec_one_bus_request_n(req1N),
    .secOneFrameN(frame1N), .secOneIrdyN(irdy1N), .sec_one_reset_out_n(rst1N), .sec_one_bus_grant_n(gnt1N),
    .sec_one_clock_fanout(fan1), .secOneClockOe(clkOe1), .secOneCtrlOe(ctrlOe1), .secOneAdOut(ad1),
    .secOneAdOe(adOe1), .secOneCbeOut(cbe1), .secOneCbeOe(cbeOe1), .secOneParOut(par1), .secOneParOe(parOe1),
    .sec_two_port_enable(en2), .sec_two_fast_clock_capable(fast2), .sec_two_bus_request_n(req2N),
    .secTwoFrameN(frame2N), .secTwoIrdyN(irdy2N), .sec_two_reset_out_n(rst2N), .sec_two_bus_grant_n(gnt2N),
    .sec_two_clock_fanout(fan2), .secTwoClockOe(clkOe2), .secTwoCtrlOe(ctrlOe2), .secTwoAdOut(ad2),
    .secTwoAdOe(adOe2), .secTwoCbeOut(cbe2), .secTwoCbeOe(cbeOe2), .secTwoParOut(par2), .secTwoParOe(parOe2));

  sprsc_bus_partner sprsc_bus_partner_inst (.ref_clk(ref_clk), .extMode(extMode), .grantLag(lag),
    .reqWant(want1), .busyWant(busy1), .grantN(gnt1N), .reqN(req1N), .frameN(frame1N), .irdyN(irdy1N));
  sprsc_bus_partner sprsc_bus_partner_two_inst (.ref_clk(ref_clk), .extMode(extMode), .grantLag(lag),
    .reqWant(want2), .busyWant(busy2), .grantN(gnt2N), .reqN(req2N), .frameN(frame2N), .irdyN(irdy2N));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic printVerdict;
    $display("checks=%0d errors=%0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : printVerdict

  // Settles after an edge so flop outputs have landed before checking
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  // Classic single cycle: hold until ack is sampled high, release after it
  task automatic wbXfer(input logic [3:0] adr, input logic we, input logic [31:0] wd);
    @(posedge ref_clk);
    wbAdr <= adr;
    wbWe <= we;
    wbSel <= 4'hf;
    wbDatI <= wd;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge ref_clk);
    end while (wbAck !== 1'b1);
    rdData = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    wbSel <= 4'h0;
  endtask : wbXfer

  task automatic wbRead(input logic [3:0] adr, input logic [31:0] exp);
    wbXfer(adr, 1'b0, 32'h0);
    chk(rdData, exp);
  endtask : wbRead

  // Primary reset for six cycles, then wait until straps are latched
  task automatic doReset;
    @(posedge ref_clk);
    arst_n <= 1'b0;
    step(3);
    chk({rst1N, rst2N, ctrlOe1, ctrlOe2, gnt1N, gnt2N}, 20'h0ffff);
    chk({adOe1, cbeOe1, parOe1, par1, cbe1}, {32'hffffffff, 4'hf, 1'b1, 1'b0, 4'h0});
    chk({ad1, ad2}, 64'h0);
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    step(1);
    chk({rst1N, rst2N}, 2'b11);
    step(6);
  endtask : doReset

  initial begin
    logic [7:0] p1, p2;
    int c1, c2;
    arst_n = 1'b0;
    {wbAdr, wbSel, wbDatI, wbWe, wbCyc, wbStb} = '0;
    priFast = 1'b1;
    fast1 = 1'b1;
    fast2 = 1'b0;
    cfnN = 1'b0;
    skip = 1'b1;
    {pllTest, sclk} = 2'b00;
    {scanN, scanCap, en1, en2} = 4'b1011;
    {want1, want2, busy1, busy2, extMode} = '0;
    lag = 4'h3;
    errCount = 0;
    numChecks = 0;
    doReset();
    wbRead(4'h4, 32'h0adc);
    wbXfer(4'h8, 1'b1, 32'hf);
    wbRead(4'h8, 32'h0);
    wbRead(4'h0, 32'h0);
    chk({adOe1, cbeOe1, parOe1, clkOe1, clkOe2}, {32'hffffffff, 4'hf, 3'b111});
    // Fast port toggles every cycle, slow one every other
    p1 = fan1;
    p2 = fan2;
    c1 = 0;
    c2 = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      c1 += (fan1 !== p1);
      c2 += (fan2 !== p2);
      p1 = fan1;
      p2 = fan2;
    end
    chk({c1[7:0], c2[7:0]}, 16'h0804);
    chk({fan1, fan2}, {{8{fan1[0]}}, {8{fan2[0]}}});
    // Lowest active request wins; park is withdrawn
    @(posedge ref_clk);
    want1 <= 8'h28;
    step(6);
    chk({gnt1N, adOe1[0], ctrlOe1}, {8'hf7, 2'b00});
    @(posedge ref_clk);
    busy1 <= 1'b1;
    // Software reset overrides a live grant on a busy bus
    wbXfer(4'h0, 1'b1, 32'h1);
    step(2);
    chk({rst1N, rst2N, gnt1N, ctrlOe1, adOe1[0]}, {2'b01, 8'hff, 2'b01});
    wbRead(4'h0, 32'h1);
    wbXfer(4'h0, 1'b1, 32'h0);
    step(2);
    chk({rst1N, rst2N}, 2'b11);
    @(posedge ref_clk);
    want1 <= 8'h0;
    busy1 <= 1'b0;
    step(6);
    chk(adOe1, 32'hffffffff);
    // Disable floats at once, before any flop could react
    @(posedge ref_clk);
    en1 <= 1'b0;
    #1;
    chk({clkOe1, ctrlOe1, parOe1, cbeOe1, adOe1}, 64'h0);
    chk({adOe2, cbeOe2, parOe2, cbe2, par2}, {32'hffffffff, 4'hf, 1'b1, 4'h0, 1'b0});
    @(posedge ref_clk);
    en1 <= 1'b1;
    scanN <= 1'b0;
    want1 <= 8'h54;
    want2 <= 8'h28;
    step(6);
    chk({gnt1N[6:2], gnt2N[6:2]}, {~want1[6:2], ~want2[6:2]});
    @(posedge ref_clk);
    scanCap <= 1'b1;
    want1 <= 8'h0;
    want2 <= 8'h0;
    step(6);
    chk({gnt1N[6:2], gnt2N[6:2]}, {5'b11100, 5'b11000});
    @(posedge ref_clk);
    {scanN, scanCap, cfnN, extMode} <= 4'b1011;
    doReset();
    wbRead(4'h4, 32'h0bd0);
    chk({gnt1N[0], gnt2N[0]}, 2'b11);
    wbXfer(4'h0, 1'b1, 32'h4);
    step(12);
    chk({gnt1N[0], gnt2N[0], req1N[0]}, 3'b010);
    wbRead(4'h4, 32'h0bd4);
    @(posedge ref_clk);
    busy1 <= 1'b1;
    step(4);
    chk(ctrlOe1, 1'b1);
    wbXfer(4'h0, 1'b1, 32'h0);
    step(12);
    chk({gnt1N[0], ctrlOe1, req1N[0]}, 3'b101);
    printVerdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    errCount++;
    printVerdict();
  end
endmodule : tb_top
`default_nettype wire
